// >>> hw/dcr_defs.svh
// constants shared by both ends of the channel readback link
// assumes inclusion by the package and by each end's module file
`ifndef DCR_DEFS_SVH
`define DCR_DEFS_SVH

// fixed upper five bits of the seven-bit slave address
`define DCR_ADDR_PREFIX  5'h13
// direction bit values
`define DCR_DIR_WRITE    1'h0
`define DCR_DIR_READ     1'h1
// control byte field positions
`define DCR_CTL_PD       0
`define DCR_CTL_SEL_LO   1
`define DCR_CTL_SEL_HI   2
`define DCR_CTL_LOAD_LO  4
`define DCR_CTL_LOAD_HI  5
`define DCR_CTL_TOP      2'h0
`define DCR_CTL_SPARE    1'h0
// readback byte fill patterns
`define DCR_PD_FILL      6'h3F
`define DCR_LO_FILL      6'h00
`define DCR_IDLE_BYTE    8'hFF
// readback byte indices, counted as if the power-down byte were sent
`define DCR_IDX_PD       2'h0
`define DCR_IDX_HI       2'h1
`define DCR_IDX_LO       2'h2
// bit and acknowledge counts
`define DCR_BITS_BYTE    4'h8
`define DCR_ACK_SEEN     4'h1
// master sequence steps
`define DCR_STEP_AW      3'h0
`define DCR_STEP_CTL     3'h1
`define DCR_STEP_AR      3'h3
`define DCR_STEP_RD0     3'h4
`define DCR_STEP_LAST2   3'h5
`define DCR_STEP_LAST3   3'h6
// quarter phases of one bus clock
`define DCR_Q0           2'h0
`define DCR_Q1           2'h1
`define DCR_Q2           2'h2
`define DCR_Q3           2'h3
// timing: 200 MHz system clock, 400 kHz fast-mode bus clock, four phases per bit
// slower rates would push one readback frame well past 40k system cycles
`define DCR_CLK_HZ       200000000
`define DCR_SCL_HZ       400000
`define DCR_QTR_CYC      (`DCR_CLK_HZ / (4 * `DCR_SCL_HZ))

`endif

// >>> hw/dcr_pkg.sv
// types shared by both ends of the channel readback link
// assumes dcr_defs.svh is on the include path
package dcr_pkg;
  `include "dcr_defs.svh"

  typedef enum logic [6:0] {
    S_IDLE     = 7'h01,
    S_ADDR     = 7'h02,
    S_ADDR_ACK = 7'h04,
    S_CTRL     = 7'h08,
    S_CTRL_ACK = 7'h10,
    S_TX       = 7'h20,
    S_TX_ACK   = 7'h40
  } dcr_sst_t;

  typedef enum logic [4:0] {
    M_IDLE  = 5'h01,
    M_START = 5'h02,
    M_XFER  = 5'h04,
    M_STOP  = 5'h08,
    M_WAIT  = 5'h10
  } dcr_mst_t;

  typedef logic [3:0][9:0] dcr_chan_val_t;
  typedef logic [3:0][1:0] dcr_chan_pd_t;
endpackage

// >>> hw/dcr_if.sv
// two-wire bus between the readback master and the converter slave
// assumes open-drain pins: a driven pin pulls low, an idle line reads high
`timescale 1ns/1ps
interface dcr_if;
  logic scl;
  logic sda;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;

  // wired-and with a pull-up: sda from both ends, scl from the master alone
  assign scl = !(m_scl_oe && !m_scl_o);
  assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));

  modport master (
    input  scl,
    input  sda,
    output m_scl_o,
    output m_scl_oe,
    output m_sda_o,
    output m_sda_oe
  );

  modport slave (
    input  scl,
    input  sda,
    output s_sda_o,
    output s_sda_oe
  );
endinterface

// >>> hw/dcr_slave.sv
// converter end: two-wire slave answering control writes and channel readback
// assumes bus pins synchronous to clk; channel values and modes from the core
// Notes on behaviour
// - acknowledge own address with write direction
// - master sends control byte; device acknowledges it
// - master repeats start, readdresses for reading
// - acknowledge read address, then transmit bytes
// - channel select bits pick returned channel
// - flag clear: send high then low byte
// - flag set: power-down, high, low bytes
// - high byte bits 9..2; low byte 1..0
// - power-down byte: mode bits, then six ones
// - master acks all but last byte
// - master ends with stop or repeated start
// - mode bits: hi-z, 1k, 100k, hi-z
`timescale 1ns/1ps
`include "dcr_defs.svh"
module dcr_slave
  import dcr_pkg::*;
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_b,
  // bus side
  dcr_if.slave               bus,
  // address pin levels
  input  wire logic          addr_pin_hi,
  input  wire logic          addr_pin_lo,
  // channel contents from the converter core
  input  wire dcr_chan_val_t chan_value,
  input  wire dcr_chan_pd_t  chan_pd_mode,
  // control byte as last received
  output logic [1:0]         channel_select,
  output logic               power_down_flag,
  output logic [1:0]         load_mode,
  output logic               ctl_valid,
  // status
  output logic               busy,
  output logic               read_done
);

  typedef struct packed {
    dcr_sst_t   st;
    logic       scl_q;
    logic       sda_q;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [1:0] idx;
    logic       rw;
    logic [1:0] sel;
    logic       pd;
    logic [1:0] load;
    logic       ctl_valid;
    logic       sda_oe;
    logic       busy;
    logic       read_done;
  } dcr_slv_t;

  dcr_slv_t r_ff;
  dcr_slv_t nxt_r;

  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  logic [6:0] own_addr;
  logic [9:0] sel_value;
  logic [1:0] sel_mode;
  logic [1:0] first_idx;
  logic [7:0] first_byte;
  logic [7:0] next_byte;

  // one builder for every readback byte
  function automatic logic [7:0] rd_byte(input logic [1:0] idx,
                                         input logic [9:0] val,
                                         input logic [1:0] mode);
    logic [7:0] b;
    b = `DCR_IDLE_BYTE;
    unique case (idx)
      `DCR_IDX_PD: b = {mode, `DCR_PD_FILL};
      `DCR_IDX_HI: b = val[9:2];
      `DCR_IDX_LO: b = {val[1:0], `DCR_LO_FILL};
      default:     b = `DCR_IDLE_BYTE;
    endcase
    return b;
  endfunction

  assign own_addr  = {`DCR_ADDR_PREFIX, addr_pin_hi, addr_pin_lo};
  assign scl_rise  = bus.scl && !r_ff.scl_q;
  assign scl_fall  = !bus.scl && r_ff.scl_q;
  assign bus_start = bus.scl && r_ff.scl_q && r_ff.sda_q && !bus.sda;
  assign bus_stop  = bus.scl && r_ff.scl_q && !r_ff.sda_q && bus.sda;
  assign sel_value = chan_value[r_ff.sel];
  // mode bits returned as stored, encoding untouched
  assign sel_mode  = chan_pd_mode[r_ff.sel];
  // byte count set by start index
  assign first_idx = r_ff.pd ? `DCR_IDX_PD : `DCR_IDX_HI;
  // a function result cannot be bit-selected, so the bytes are named here
  assign first_byte = rd_byte(first_idx, sel_value, sel_mode);
  assign next_byte  = rd_byte(r_ff.idx, sel_value, sel_mode);

  always_comb begin
    nxt_r           = r_ff;
    nxt_r.scl_q     = bus.scl;
    nxt_r.sda_q     = bus.sda;
    nxt_r.read_done = 1'b0;
    if (bus_start) begin
      // repeated start restarts addressing from any state
      nxt_r.st     = S_ADDR;
      nxt_r.cnt    = '0;
      nxt_r.sda_oe = 1'b0;
    end else if (bus_stop) begin
      nxt_r.st     = S_IDLE;
      nxt_r.sda_oe = 1'b0;
    end else begin
      unique case (r_ff.st)
        S_IDLE: begin
          nxt_r.sda_oe = 1'b0;
        end
        S_ADDR, S_CTRL: begin
          if (scl_rise && r_ff.cnt != `DCR_BITS_BYTE) begin
            nxt_r.sh  = {r_ff.sh[6:0], bus.sda};
            nxt_r.cnt = r_ff.cnt + 4'h1;
          end
          if (scl_fall && r_ff.cnt == `DCR_BITS_BYTE) begin
            nxt_r.cnt = '0;
            if (r_ff.st == S_ADDR) begin
              if (r_ff.sh[7:1] == own_addr) begin
                nxt_r.st     = S_ADDR_ACK;
                nxt_r.rw     = r_ff.sh[0];
                nxt_r.sda_oe = 1'b1;
              end else begin
                nxt_r.st = S_IDLE;
              end
            end else begin
              nxt_r.pd        = r_ff.sh[`DCR_CTL_PD];
              nxt_r.sel       = {r_ff.sh[`DCR_CTL_SEL_HI], r_ff.sh[`DCR_CTL_SEL_LO]};
              nxt_r.load      = {r_ff.sh[`DCR_CTL_LOAD_HI], r_ff.sh[`DCR_CTL_LOAD_LO]};
              nxt_r.ctl_valid = 1'b1;
              nxt_r.st        = S_CTRL_ACK;
              nxt_r.sda_oe    = 1'b1;
            end
          end
        end
        S_ADDR_ACK: begin
          if (scl_fall) begin
            nxt_r.cnt = '0;
            if (r_ff.rw == `DCR_DIR_READ) begin
              // first readback bit driven right after the acknowledge
              nxt_r.idx    = first_idx;
              nxt_r.sh     = first_byte;
              nxt_r.sda_oe = !first_byte[7];
              nxt_r.st     = S_TX;
            end else begin
              nxt_r.sda_oe = 1'b0;
              nxt_r.st     = S_CTRL;
            end
          end
        end
        S_CTRL_ACK: begin
          // data bytes of a write are not taken by this path
          if (scl_fall) begin
            nxt_r.sda_oe = 1'b0;
            nxt_r.st     = S_IDLE;
          end
        end
        S_TX: begin
          if (scl_rise) begin
            nxt_r.cnt = r_ff.cnt + 4'h1;
          end
          if (scl_fall) begin
            if (r_ff.cnt == `DCR_BITS_BYTE) begin
              nxt_r.cnt    = '0;
              nxt_r.sda_oe = 1'b0;
              nxt_r.st     = S_TX_ACK;
            end else begin
              nxt_r.sh     = {r_ff.sh[6:0], 1'b1};
              nxt_r.sda_oe = !r_ff.sh[6];
            end
          end
        end
        S_TX_ACK: begin
          if (scl_rise) begin
            // a nack, or an ack after the low byte, ends the read
            if (bus.sda || r_ff.idx == `DCR_IDX_LO) begin
              nxt_r.read_done = 1'b1;
              nxt_r.st        = S_IDLE;
            end else begin
              nxt_r.cnt = `DCR_ACK_SEEN;
              nxt_r.idx = r_ff.idx + 2'h1;
            end
          end
          if (scl_fall && r_ff.cnt == `DCR_ACK_SEEN) begin
            nxt_r.cnt    = '0;
            nxt_r.sh     = next_byte;
            nxt_r.sda_oe = !next_byte[7];
            nxt_r.st     = S_TX;
          end
        end
      endcase
    end
    nxt_r.busy = (nxt_r.st != S_IDLE);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r_ff <= '{st: S_IDLE, scl_q: 1'b1, sda_q: 1'b1, default: '0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  // open drain: only ever pulls low
  assign bus.s_sda_o     = 1'b0;
  assign bus.s_sda_oe    = r_ff.sda_oe;
  assign channel_select  = r_ff.sel;
  assign power_down_flag = r_ff.pd;
  assign load_mode       = r_ff.load;
  assign ctl_valid       = r_ff.ctl_valid;
  assign busy            = r_ff.busy;
  assign read_done       = r_ff.read_done;

endmodule

// >>> hw/dcr_master.sv
// master end: runs one control write plus readback per request
// assumes bus pins synchronous to clk; bus clock made from clk by a divider
`timescale 1ns/1ps
`include "dcr_defs.svh"
module dcr_master
  import dcr_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // bus side
  dcr_if.master           bus,
  // request
  input  wire logic       go,
  input  wire logic       addr_pin_hi,
  input  wire logic       addr_pin_lo,
  input  wire logic [1:0] channel_select,
  input  wire logic       power_down_flag,
  input  wire logic [1:0] load_mode,
  // answer
  output logic            busy,
  output logic            done,
  output logic            nack_err,
  output logic [7:0]      rd_pd_byte,
  output logic [7:0]      rd_hi_byte,
  output logic [7:0]      rd_lo_byte
);

  typedef struct packed {
    dcr_mst_t   st;
    logic [9:0] div;
    logic [1:0] q;
    logic [2:0] step;
    logic [8:0] sh;
    logic [8:0] rx;
    logic [3:0] bcnt;
    logic [6:0] addr;
    logic [7:0] ctl;
    logic       pd;
    logic       scl_oe;
    logic       sda_oe;
    logic       busy;
    logic       done;
    logic       nack_err;
    logic [7:0] rd_pd;
    logic [7:0] rd_hi;
    logic [7:0] rd_lo;
  } dcr_mst_st_t;

  dcr_mst_st_t r_ff;
  dcr_mst_st_t nxt_r;
  logic        tick;
  logic [2:0]  last_step;

  // byte plus the level sent in the acknowledge slot
  function automatic logic [8:0] step_word(input logic [2:0] step, input logic [6:0] addr,
                                           input logic [7:0] ctl, input logic [2:0] last);
    logic [8:0] w;
    w = {`DCR_IDLE_BYTE, 1'b1};
    if (step == `DCR_STEP_AW) begin
      w = {addr, `DCR_DIR_WRITE, 1'b1};
    end else if (step == `DCR_STEP_CTL) begin
      w = {ctl, 1'b1};
    end else if (step == `DCR_STEP_AR) begin
      w = {addr, `DCR_DIR_READ, 1'b1};
    end else begin
      // ack every byte but the last
      w = {`DCR_IDLE_BYTE, step == last};
    end
    return w;
  endfunction

  assign tick      = (r_ff.div == 10'(`DCR_QTR_CYC - 1));
  assign last_step = r_ff.pd ? `DCR_STEP_LAST3 : `DCR_STEP_LAST2;

  always_comb begin
    nxt_r      = r_ff;
    nxt_r.done = 1'b0;
    nxt_r.div  = (tick || r_ff.st == M_IDLE) ? '0 : r_ff.div + 10'h1;
    if (tick) begin
      nxt_r.q = r_ff.q + 2'h1;
    end
    unique case (r_ff.st)
      M_IDLE: begin
        nxt_r.q = `DCR_Q0;
        if (go) begin
          // address and control byte built from the request
          nxt_r.addr     = {`DCR_ADDR_PREFIX, addr_pin_hi, addr_pin_lo};
          nxt_r.ctl      = {`DCR_CTL_TOP, load_mode, `DCR_CTL_SPARE, channel_select,
                            power_down_flag};
          nxt_r.pd       = power_down_flag;
          nxt_r.step     = `DCR_STEP_AW;
          nxt_r.nack_err = 1'b0;
          nxt_r.busy     = 1'b1;
          nxt_r.st       = M_START;
        end
      end
      M_START: begin
        if (tick) begin
          unique case (r_ff.q)
            `DCR_Q0: begin
              nxt_r.sda_oe = 1'b0;
              nxt_r.scl_oe = 1'b1;
            end
            `DCR_Q1: nxt_r.scl_oe = 1'b0;
            `DCR_Q2: nxt_r.sda_oe = 1'b1;
            `DCR_Q3: begin
              nxt_r.scl_oe = 1'b1;
              nxt_r.bcnt   = '0;
              nxt_r.sh     = step_word(r_ff.step, r_ff.addr, r_ff.ctl, last_step);
              nxt_r.st     = M_XFER;
            end
          endcase
        end
      end
      M_XFER: begin
        if (tick) begin
          unique case (r_ff.q)
            `DCR_Q0: nxt_r.sda_oe = !r_ff.sh[8];
            `DCR_Q1: nxt_r.scl_oe = 1'b0;
            `DCR_Q2: nxt_r.rx = {r_ff.rx[7:0], bus.sda};
            `DCR_Q3: begin
              nxt_r.scl_oe = 1'b1;
              nxt_r.sh     = {r_ff.sh[7:0], 1'b1};
              nxt_r.bcnt   = r_ff.bcnt + 4'h1;
              if (r_ff.bcnt == `DCR_BITS_BYTE) begin
                nxt_r.bcnt = '0;
                nxt_r.step = r_ff.step + 3'h1;
                if (r_ff.step < `DCR_STEP_RD0 && r_ff.rx[0]) begin
                  nxt_r.nack_err = 1'b1;
                  nxt_r.st       = M_STOP;
                end else if (r_ff.step == `DCR_STEP_CTL) begin
                  nxt_r.step = `DCR_STEP_AR;
                  nxt_r.st   = M_START;
                end else if (r_ff.step >= `DCR_STEP_RD0) begin
                  if (r_ff.step == last_step) begin
                    nxt_r.rd_lo = r_ff.rx[8:1];
                    nxt_r.st    = M_STOP;
                  end else if (r_ff.step == `DCR_STEP_RD0 && r_ff.pd) begin
                    nxt_r.rd_pd = r_ff.rx[8:1];
                  end else begin
                    nxt_r.rd_hi = r_ff.rx[8:1];
                  end
                end
                if (nxt_r.st == M_XFER) begin
                  nxt_r.sh = step_word(nxt_r.step, r_ff.addr, r_ff.ctl, last_step);
                end
              end
            end
          endcase
        end
      end
      M_STOP: begin
        if (tick) begin
          unique case (r_ff.q)
            `DCR_Q0: nxt_r.sda_oe = 1'b1;
            `DCR_Q1: nxt_r.scl_oe = 1'b0;
            `DCR_Q2: nxt_r.sda_oe = 1'b0;
            `DCR_Q3: nxt_r.st = M_WAIT;
          endcase
        end
      end
      M_WAIT: begin
        // bus free time before the next request
        if (tick && r_ff.q == `DCR_Q3) begin
          nxt_r.busy = 1'b0;
          nxt_r.done = 1'b1;
          nxt_r.st   = M_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r_ff <= '{st: M_IDLE, default: '0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign bus.m_scl_o  = 1'b0;
  assign bus.m_scl_oe = r_ff.scl_oe;
  assign bus.m_sda_o  = 1'b0;
  assign bus.m_sda_oe = r_ff.sda_oe;
  assign busy         = r_ff.busy;
  assign done         = r_ff.done;
  assign nack_err     = r_ff.nack_err;
  assign rd_pd_byte   = r_ff.rd_pd;
  assign rd_hi_byte   = r_ff.rd_hi;
  assign rd_lo_byte   = r_ff.rd_lo;

endmodule

// >>> testbench/dcr_link_asserts.sv
// bus-level checks on the link joining master and slave ends
// assumes the plain signals of dcr_if plus the shared clock and reset
`timescale 1ns/1ps
`include "dcr_defs.svh"
module dcr_link_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // resolved lines
  input wire logic scl,
  input wire logic sda,
  // master pins
  input wire logic m_scl_o,
  input wire logic m_scl_oe,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  // slave pins
  input wire logic s_sda_o,
  input wire logic s_sda_oe
);
  localparam int QTR = `DCR_QTR_CYC;
  logic [15:0] lo_cnt_ff;
  logic [15:0] nxt_lo_cnt;

  // cycles of bus clock low so far
  always_comb nxt_lo_cnt = scl ? 16'h0 : lo_cnt_ff + 16'h1;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lo_cnt_ff <= 16'h0;
    end else begin
      lo_cnt_ff <= nxt_lo_cnt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_open_drain: assert property (!m_scl_o && !m_sda_o && !s_sda_o)
    else $error("open-drain pin driven high");
  chk_release_idle: assert property ($rose(rst_b) |-> !m_scl_oe && !m_sda_oe && !s_sda_oe)
    else $error("line pulled low right after reset");
  chk_slave_edge: assert property ($changed(s_sda_oe) |-> !$past(scl) && $past(scl, 2))
    else $error("slave data moved away from bus clock fall");
  chk_slave_hold: assert property ($rose(scl) |-> $stable(s_sda_oe)[*8])
    else $error("slave data moved while bus clock high");
  chk_start_by_master: assert property (scl && $past(scl) && $fell(sda) |-> $rose(m_sda_oe))
    else $error("start condition not made by master");
  chk_stop_release: assert property (scl && $past(scl) && $rose(sda) |-> !s_sda_oe)
    else $error("stop while slave still drives");
  chk_low_time: assert property ($rose(scl) |-> lo_cnt_ff == 2 * QTR || lo_cnt_ff == QTR)
    else $error("bus clock low time off");
  chk_master_yields: assert property ($rose(scl) && s_sda_oe |-> !m_sda_oe)
    else $error("master drives during slave bit");

  cov_start: cover property (scl && $fell(sda));
  cov_stop: cover property (scl && $rose(sda));
  cov_slave_drive: cover property ($rose(s_sda_oe));
endmodule

// >>> testbench/tb.sv
// self-checking bench: master and slave ends joined over one bus
// assumes design files and the link checker are compiled before it
`timescale 1ns/1ps
module tb
  import dcr_pkg::*;
;
  localparam logic [9:0] V1 = 10'h1CA;
  localparam logic [9:0] V2 = 10'h2B5;
  logic          clk;
  logic          rst_b;
  logic          go;
  logic          m_hi;
  logic          m_lo;
  logic [1:0]    m_sel;
  logic          m_pd;
  logic [1:0]    m_ld;
  logic          m_busy;
  logic          done;
  logic          nack_err;
  logic [7:0]    rd_pd;
  logic [7:0]    rd_hi;
  logic [7:0]    rd_lo;
  dcr_chan_val_t chan_value;
  dcr_chan_pd_t  chan_pd_mode;
  logic [1:0]    s_sel;
  logic          s_pd;
  logic [1:0]    s_ld;
  logic          ctl_valid;
  logic          read_done;
  logic          s_busy;
  logic          scl_q = 1'b1;
  int            rises;
  int            rdone;
  int            nrise;
  int            ndone;
  int            failures;
  int            compares;

  dcr_if u_dcr_if ();
  dcr_master u_dcr_master (.clk(clk), .rst_b(rst_b), .bus(u_dcr_if), .go(go),
    .addr_pin_hi(m_hi), .addr_pin_lo(m_lo), .channel_select(m_sel),
    .power_down_flag(m_pd), .load_mode(m_ld), .busy(m_busy), .done(done),
    .nack_err(nack_err), .rd_pd_byte(rd_pd), .rd_hi_byte(rd_hi), .rd_lo_byte(rd_lo));
  dcr_slave u_dcr_slave (.clk(clk), .rst_b(rst_b), .bus(u_dcr_if), .addr_pin_hi(1'b0),
    .addr_pin_lo(1'b1), .chan_value(chan_value), .chan_pd_mode(chan_pd_mode),
    .channel_select(s_sel), .power_down_flag(s_pd), .load_mode(s_ld),
    .ctl_valid(ctl_valid), .busy(s_busy), .read_done(read_done));
  dcr_link_asserts u_dcr_link_asserts (.clk(clk), .rst_b(rst_b), .scl(u_dcr_if.scl),
    .sda(u_dcr_if.sda), .m_scl_o(u_dcr_if.m_scl_o), .m_scl_oe(u_dcr_if.m_scl_oe),
    .m_sda_o(u_dcr_if.m_sda_o), .m_sda_oe(u_dcr_if.m_sda_oe),
    .s_sda_o(u_dcr_if.s_sda_o), .s_sda_oe(u_dcr_if.s_sda_oe));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // sampled away from the launching edge to avoid races
  always @(negedge clk) begin
    if (u_dcr_if.scl === 1'b1 && scl_q === 1'b0) begin
      rises++;
    end
    if (read_done === 1'b1) begin
      rdone++;
    end
    scl_q <= u_dcr_if.scl;
  end

  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // one request, waits for done; frames last up to about 30k cycles
  task automatic xfer(input logic a_hi, input logic a_lo, input logic [1:0] sel,
                      input logic p, input logic [1:0] ld);
    int n;
    int r0;
    int d0;
    r0 = rises;
    d0 = rdone;
    n = 0;
    @(posedge clk);
    m_hi <= a_hi;
    m_lo <= a_lo;
    m_sel <= sel;
    m_pd <= p;
    m_ld <= ld;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && n < 40000);
    if (done !== 1'b1) begin
      failures++;
      print_verdict();
    end
    check("busy_at_done", {9'h0, m_busy}, 10'h0);
    check("slave_idle", {9'h0, s_busy}, 10'h0);
    repeat (4) @(negedge clk);
    nrise = rises - r0;
    ndone = rdone - d0;
  endtask

  task automatic t_read3();
    xfer(1'b0, 1'b1, 2'h2, 1'b1, 2'h3);
    check("nack3", {9'h0, nack_err}, 10'h0);
    check("ctl_valid", {9'h0, ctl_valid}, 10'h1);
    check("sel3", {8'h0, s_sel}, 10'h2);
    check("pd3", {9'h0, s_pd}, 10'h1);
    check("load3", {8'h0, s_ld}, 10'h3);
    check("pd_byte", {2'h0, rd_pd}, {2'h0, chan_pd_mode[2], 6'h3F});
    check("hi3", {2'h0, rd_hi}, {2'h0, V2[9:2]});
    check("lo3", {8'h0, rd_lo[7:6]}, {8'h0, V2[1:0]});
    check("rises3", nrise[9:0], 10'h039);
    check("rdone3", ndone[9:0], 10'h001);
  endtask

  task automatic t_read2();
    xfer(1'b0, 1'b1, 2'h1, 1'b0, 2'h1);
    check("nack2", {9'h0, nack_err}, 10'h0);
    check("sel2", {8'h0, s_sel}, 10'h1);
    check("pd2", {9'h0, s_pd}, 10'h0);
    check("hi2", {2'h0, rd_hi}, {2'h0, V1[9:2]});
    check("lo2", {8'h0, rd_lo[7:6]}, {8'h0, V1[1:0]});
    check("rises2", nrise[9:0], 10'h030);
    check("rdone2", ndone[9:0], 10'h001);
  endtask

  // wrong address pins: no ack, control fields keep old values
  task automatic t_bad_addr();
    xfer(1'b1, 1'b0, 2'h3, 1'b1, 2'h2);
    check("nack_bad", {9'h0, nack_err}, 10'h1);
    check("sel_bad", {8'h0, s_sel}, 10'h1);
    check("rises_bad", nrise[9:0], 10'h00B);
    check("rdone_bad", ndone[9:0], 10'h000);
  endtask

  initial begin
    rst_b = 1'b0;
    go = 1'b0;
    m_hi = 1'b0;
    m_lo = 1'b0;
    m_sel = 2'h0;
    m_pd = 1'b0;
    m_ld = 2'h0;
    chan_value = {10'h0F0, V2, V1, 10'h30C};
    // mode 01 exposes a swapped bit order
    chan_pd_mode = {2'h3, 2'h1, 2'h2, 2'h0};
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_read3();
    t_read2();
    t_bad_addr();
    print_verdict();
  end
endmodule
